//--- tcs_regs.svh
// Purpose: Offsets, field positions, reset values of the trap control block
// Assumes: 32-bit AXI4-Lite words, 16-bit control and 8-bit interrupt registers in the low bits
// Notes:   Definitions only
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_OFF_CTRL      12'h000
`define TCS_OFF_IRQ_STAT  12'h004
`define TCS_OFF_IRQ_MASK  12'h008
`define TCS_CTRL_RST      16'h0000
`define TCS_IRQ_RST       8'h00
`define TCS_B_NESTING_DISABLE      15
`define TCS_B_OVA         14
`define TCS_B_OVB         13
`define TCS_B_COVA        12
`define TCS_B_COVB        11
`define TCS_B_ACC_A_OVERFLOW_TRAP_EN       10
`define TCS_B_ACC_B_OVERFLOW_TRAP_EN       9
`define TCS_B_CATASTROPHIC_TRAP_EN       8
`define TCS_B_SFT         7
`define TCS_B_DIV0        6
`define TCS_B_MATH        4
`define TCS_B_ADDR        3
`define TCS_B_STK         2
`define TCS_B_OSC         1
`define TCS_IMPL_MASK     16'hffde
`define TCS_FLAG_MASK     16'h78de
`define TCS_RESP_OKAY     2'b00
`define TCS_RESP_SLVERR   2'b10
`endif

//--- tcs_pkg.sv
// Purpose: Types shared by the trap control block
// Assumes: Included constants header
// Notes:   Event carrier and write-channel state encoding
package tcs_pkg;
  typedef struct packed {
    logic ovf_a;
    logic ovf_b;
    logic cat_a;
    logic cat_b;
    logic bad_shift;
    logic div_zero;
    logic addr_err;
    logic stack_err;
    logic osc_fail;
  } tcs_evt_t;
  typedef enum logic [2:0] {
    TCS_W_IDLE = 3'b001,
    TCS_W_RESP = 3'b010,
    TCS_W_WAIT = 3'b100
  } tcs_wst_t;
endpackage : tcs_pkg

//--- tcs_sync.sv
// Purpose: Two-flop synchroniser for a bus of levels
// Assumes: Single clock, asynchronous active-low reset
// Notes:   First stage read only by the second
`timescale 1ns/1ps
module tcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : tcs_sync

//--- tcs_trap_ctrl.sv
// Purpose: Trap control and status register with AXI4-Lite access
// Assumes: Core event pulses are on REF_CLK; osc failure comes from a pin
// Notes:   Status flags are sticky; software clears control flags by writing 0, interrupt status bits by writing 1
`timescale 1ns/1ps
`include "tcs_regs.svh"
// Overview of operation
// RULE_01: Bit 15 set blocks interrupt nesting; clear allows nesting.
// RULE_02: Bit 14 records a trap caused by accumulator A overflow.
// RULE_03: Bit 13 records a trap caused by accumulator B overflow.
// RULE_04: Bit 12 records a catastrophic accumulator A overflow trap.
// RULE_05: Bit 11 records a catastrophic accumulator B overflow trap.
// RULE_06: Bit 10 enables the accumulator A overflow trap.
// RULE_07: Bit 9 enables the accumulator B overflow trap.
// RULE_08: Bit 8 enables catastrophic overflow traps for either accumulator.
// RULE_09: Bit 7 records a math trap from an invalid accumulator shift.
// RULE_10: Bit 6 records a math trap from a divide by zero.
// RULE_11: Bit 4 records any math trap; bit 5 reads zero.
// RULE_12: Bit 3 records an address error trap.
// RULE_13: Bit 2 stack error, bit 1 oscillator failure; bit 0 reads zero.
// RULE_14: All bits reset to 0; flags stay set until written 0.
module tcs_trap_ctrl
  import tcs_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire tcs_evt_t    CORE_EVT,
  input  wire logic        OSC_FAIL_PIN,
  output logic             MATH_TRAP,
  output logic             ADDR_TRAP,
  output logic             NESTING_DISABLE,
  output logic             IRQ
);
  logic [15:0] ctrl_r;
  logic [7:0]  irq_stat_r;
  logic [7:0]  irq_mask_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_have_r;
  logic        w_have_r;
  tcs_wst_t    wst_r;
  logic        osc_sync;
  logic        osc_prev_r;
  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic [15:0] wval;
  logic [15:0] set_v;
  logic        t_ova;
  logic        t_ovb;
  logic        t_cova;
  logic        t_covb;
  logic        t_math;
  logic        t_addr;
  logic        t_osc;
  logic [7:0]  irq_evt;

  tcs_sync #(.W(1)) u_osc_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     (OSC_FAIL_PIN),
    .q     (osc_sync)
  );

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_sync;
    end
  end

  // Trap qualification by enables
  assign t_ova  = CORE_EVT.ovf_a & ctrl_r[`TCS_B_ACC_A_OVERFLOW_TRAP_EN];  // [RULE_06]
  assign t_ovb  = CORE_EVT.ovf_b & ctrl_r[`TCS_B_ACC_B_OVERFLOW_TRAP_EN];  // [RULE_07]
  assign t_cova = CORE_EVT.cat_a & ctrl_r[`TCS_B_CATASTROPHIC_TRAP_EN];  // [RULE_08]
  assign t_covb = CORE_EVT.cat_b & ctrl_r[`TCS_B_CATASTROPHIC_TRAP_EN];  // [RULE_08]
  assign t_math = t_ova | t_ovb | t_cova | t_covb
                | CORE_EVT.bad_shift | CORE_EVT.div_zero;
  assign t_addr = CORE_EVT.addr_err;
  assign t_osc  = osc_sync & ~osc_prev_r;

  always_comb begin
    set_v = 16'h0000;
    set_v[`TCS_B_OVA]  = t_ova;                    // [RULE_02]
    set_v[`TCS_B_OVB]  = t_ovb;                    // [RULE_03]
    set_v[`TCS_B_COVA] = t_cova;                   // [RULE_04]
    set_v[`TCS_B_COVB] = t_covb;                   // [RULE_05]
    set_v[`TCS_B_SFT]  = CORE_EVT.bad_shift;       // [RULE_09]
    set_v[`TCS_B_DIV0] = CORE_EVT.div_zero;        // [RULE_10]
    set_v[`TCS_B_MATH] = t_math;                   // [RULE_11]
    set_v[`TCS_B_ADDR] = t_addr;                   // [RULE_12]
    set_v[`TCS_B_STK]  = CORE_EVT.stack_err;       // [RULE_13]
    set_v[`TCS_B_OSC]  = t_osc;                    // [RULE_13]
  end

  // Write channel: address and data accepted in either order
  assign wr_fire = aw_have_r & w_have_r & (wst_r == TCS_W_IDLE);
  assign wr_ctrl = wr_fire & (awaddr_r == `TCS_OFF_CTRL);
  assign wr_stat = wr_fire & (awaddr_r == `TCS_OFF_IRQ_STAT);
  assign wr_mask = wr_fire & (awaddr_r == `TCS_OFF_IRQ_MASK);

  always_comb begin
    wval = ctrl_r;
    if (wstrb_r[0]) begin
      wval[7:0] = wdata_r[7:0];
    end
    if (wstrb_r[1]) begin
      wval[15:8] = wdata_r[15:8];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_have_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY  <= ~w_have_r & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {S_AXI_AWADDR[11:2], 2'b00};
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb_r  <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wst_r        <= TCS_W_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `TCS_RESP_OKAY;
    end else begin
      unique case (wst_r)
        TCS_W_IDLE: begin
          if (wr_fire) begin
            wst_r        <= TCS_W_RESP;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wr_ctrl | wr_stat | wr_mask) ?
                            `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
          end
        end
        TCS_W_RESP: begin
          if (S_AXI_BREADY) begin
            wst_r        <= TCS_W_WAIT;
            S_AXI_BVALID <= 1'b0;
          end
        end
        TCS_W_WAIT: begin
          wst_r <= TCS_W_IDLE;
        end
      endcase
    end
  end

  // Control bits written directly; flags sticky, set wins over a write of 0
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= `TCS_CTRL_RST;                             // [RULE_14]
    end else if (wr_ctrl) begin
      ctrl_r <= ((wval & ctrl_r) | (wval & ~`TCS_FLAG_MASK) | set_v)
                & `TCS_IMPL_MASK;                          // [RULE_14]
    end else begin
      ctrl_r <= (ctrl_r | set_v) & `TCS_IMPL_MASK;         // [RULE_11]
    end
  end

  // Interrupt status: one bit per status flag group
  assign irq_evt = {t_ova | t_ovb, t_cova | t_covb, CORE_EVT.bad_shift,
                    CORE_EVT.div_zero, t_math, t_addr,
                    CORE_EVT.stack_err, t_osc};

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_stat_r <= `TCS_IRQ_RST;
      irq_mask_r <= `TCS_IRQ_RST;
    end else begin
      if (wr_stat) begin
        irq_stat_r <= (irq_stat_r & ~wdata_r[7:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_mask) begin
        irq_mask_r <= wdata_r[7:0];
      end
    end
  end

  // Read channel
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `TCS_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `TCS_RESP_OKAY;
        unique case ({S_AXI_ARADDR[11:2], 2'b00})
          `TCS_OFF_CTRL:     S_AXI_RDATA <= {16'h0000, ctrl_r};
          `TCS_OFF_IRQ_STAT: S_AXI_RDATA <= {24'h000000, irq_stat_r};
          `TCS_OFF_IRQ_MASK: S_AXI_RDATA <= {24'h000000, irq_mask_r};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `TCS_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MATH_TRAP       <= 1'b0;
      ADDR_TRAP       <= 1'b0;
      NESTING_DISABLE <= 1'b0;
      IRQ             <= 1'b0;
    end else begin
      MATH_TRAP       <= t_math;
      ADDR_TRAP       <= t_addr;
      NESTING_DISABLE <= ctrl_r[`TCS_B_NESTING_DISABLE];            // [RULE_01]
      IRQ             <= |(irq_stat_r & irq_mask_r);
    end
  end

  default clocking cb_chk @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  a_ova_gated: assert property ( // [RULE_06]
    CORE_EVT.ovf_a & ~ctrl_r[`TCS_B_ACC_A_OVERFLOW_TRAP_EN] & ~ctrl_r[`TCS_B_OVA]
      |=> ~ctrl_r[`TCS_B_OVA])
    else $error("overflow A flag set while trap disabled");
  a_ovb_flag: assert property ( // [RULE_03]
    t_ovb |=> ctrl_r[`TCS_B_OVB])
    else $error("overflow B flag not set");
  a_ova_flag: assert property ( // [RULE_02]
    t_ova |=> ctrl_r[`TCS_B_OVA] && MATH_TRAP)
    else $error("overflow A flag or trap missing");
  a_cat_flag: assert property ( // [RULE_05]
    CORE_EVT.cat_b & ctrl_r[`TCS_B_CATASTROPHIC_TRAP_EN] |=> ctrl_r[`TCS_B_COVB])
    else $error("catastrophic B flag not set");
  a_cat_off: assert property ( // [RULE_04]
    ~ctrl_r[`TCS_B_COVA] & ~CORE_EVT.cat_a |=> ~ctrl_r[`TCS_B_COVA])
    else $error("catastrophic A flag set without cause");
  a_math_flag: assert property ( // [RULE_10]
    CORE_EVT.div_zero |=> ctrl_r[`TCS_B_DIV0] && ctrl_r[`TCS_B_MATH])
    else $error("divide by zero flags not set");
  a_unimpl_zero: assert property ( // [RULE_13]
    ctrl_r[5] == 1'b0 && ctrl_r[0] == 1'b0)
    else $error("unimplemented bit set");
  a_sticky_hold: assert property ( // [RULE_14]
    ctrl_r[`TCS_B_ADDR] & ~wr_ctrl |=> ctrl_r[`TCS_B_ADDR])
    else $error("address flag lost without a write");
  a_nest_out: assert property ( // [RULE_01]
    ##1 NESTING_DISABLE == $past(ctrl_r[`TCS_B_NESTING_DISABLE]))
    else $error("nesting disable output mismatch");
  a_shift_flag: assert property ( // [RULE_09]
    CORE_EVT.bad_shift |=> ctrl_r[`TCS_B_SFT])
    else $error("shift error flag not set");
  a_addr_flag: assert property ( // [RULE_12]
    t_addr |=> ctrl_r[`TCS_B_ADDR] && ADDR_TRAP)
    else $error("address error flag not set");
  a_ovb_gated: assert property ( // [RULE_07]
    CORE_EVT.ovf_b & ~ctrl_r[`TCS_B_ACC_B_OVERFLOW_TRAP_EN] & ~ctrl_r[`TCS_B_OVB]
      |=> ~ctrl_r[`TCS_B_OVB])
    else $error("overflow B flag set while trap disabled");
  a_cat_gated: assert property ( // [RULE_08]
    ~ctrl_r[`TCS_B_CATASTROPHIC_TRAP_EN] & ~ctrl_r[`TCS_B_COVA] & ~ctrl_r[`TCS_B_COVB]
      |=> ~ctrl_r[`TCS_B_COVA] & ~ctrl_r[`TCS_B_COVB])
    else $error("catastrophic flag set while trap disabled");
  a_math_any: assert property ( // [RULE_11]
    t_math |=> ctrl_r[`TCS_B_MATH])
    else $error("math error flag not set");

  c_write_ctrl: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    wr_ctrl ##1 S_AXI_BVALID);
  c_read_back:  cover property (@(posedge REF_CLK) disable iff (!RST_B)
    S_AXI_RVALID & S_AXI_RREADY);
  c_irq_rise:   cover property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(IRQ));
  c_osc_fail:   cover property (@(posedge REF_CLK) disable iff (!RST_B)
    t_osc ##1 ctrl_r[`TCS_B_OSC]);
endmodule : tcs_trap_ctrl

//--- tcs_core_model.sv
// Purpose: Core datapath stand-in that issues trap event pulses
// Assumes: Same clock and reset as the trap block
// Notes:   Events are one-cycle pulses and idle low between them
`timescale 1ns/1ps
module tcs_core_model
  import tcs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_b,
  input  wire logic     go,
  input  wire tcs_evt_t evt,
  output tcs_evt_t      core_evt
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      core_evt <= '0;
    else if (go)
      core_evt <= evt;
    else
      core_evt <= '0;
  end
endmodule : tcs_core_model

//--- testbench.sv
// Purpose: Self-checking bench for the trap control block
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes:   Control, status and mask are mirrored in plain vectors
`timescale 1ns/1ps
`include "tcs_regs.svh"
module testbench
  import tcs_pkg::*;
;
  logic        clk = 0;
  logic        rst_b = 0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, go = 0, osc = 0;
  tcs_evt_t    evt = '0;
  tcs_evt_t    core_evt;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         math_trap, addr_trap, nest_dis, irq;
  int          bad_count = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'hc497598f;
  logic [31:0] rd_d;
  logic [1:0]  resp;
  logic [15:0] m_ctrl = '0;
  logic [7:0]  m_stat = '0, m_mask = '0;

  always #5 clk = ~clk;

  tcs_core_model pm (.clk(clk), .rst_b(rst_b), .go(go), .evt(evt),
    .core_evt(core_evt));
  tcs_trap_ctrl uut (.REF_CLK(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CORE_EVT(core_evt), .OSC_FAIL_PIN(osc),
    .MATH_TRAP(math_trap), .ADDR_TRAP(addr_trap),
    .NESTING_DISABLE(nest_dis), .IRQ(irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wready) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    while (!bvalid) @(posedge clk);
    resp = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    while (!arready) @(posedge clk);
    arvalid <= 0;
    rready <= 1;
    while (!rvalid) @(posedge clk);
    rd_d = rdata;
    resp = rresp;
    rready <= 0;
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e,
                    input string nm);
    rd(a);
    chk(nm, e, rd_d);
    chk("rresp", `TCS_RESP_OKAY, resp);
  endtask : rc

  // Flags survive a write only where the written bit is 1
  task automatic wctl(input logic [15:0] d, input logic [3:0] s);
    logic [15:0] dd;
    dd = {s[1] ? d[15:8] : m_ctrl[15:8], s[0] ? d[7:0] : m_ctrl[7:0]};
    wstrb <= s;
    wr(`TCS_OFF_CTRL, {16'h0, d});
    chk("bresp", `TCS_RESP_OKAY, resp);
    m_ctrl = (dd & 16'h8700) | (m_ctrl & dd & 16'h78de);
    @(posedge clk);
    chk("nest_dis", m_ctrl[15], nest_dis);
  endtask : wctl

  task automatic ev(input tcs_evt_t e);
    logic [3:0] q;
    logic       mth;
    q = {e.ovf_a & m_ctrl[10], e.ovf_b & m_ctrl[9],
         e.cat_a & m_ctrl[8], e.cat_b & m_ctrl[8]};
    mth = (|q) | e.bad_shift | e.div_zero;
    m_ctrl |= {1'b0, q, 3'b0, e.bad_shift, e.div_zero, 1'b0, mth,
               e.addr_err, e.stack_err, 2'b0};
    m_stat |= {q[3] | q[2], q[1] | q[0], e.bad_shift, e.div_zero, mth,
               e.addr_err, e.stack_err, 1'b0};
    @(posedge clk);
    go <= 1;
    evt <= e;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    #1;
    chk("math_trap", mth, math_trap);
    chk("addr_trap", e.addr_err, addr_trap);
    @(posedge clk);
    #1;
    chk("math_trap_end", 0, math_trap);
    chk("irq", |(m_stat & m_mask), irq);
  endtask : ev

  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    rc(`TCS_OFF_CTRL, 0, "ctrl_rst");
    rc(`TCS_OFF_IRQ_STAT, 0, "stat_rst");
    rc(`TCS_OFF_IRQ_MASK, 0, "mask_rst");
    $display("test reset done");
    rd(12'h00c);
    chk("rresp_unmapped", `TCS_RESP_SLVERR, resp);
    chk("rdata_unmapped", 0, rd_d);
    wr(12'h010, 32'hffff_ffff);
    chk("bresp_unmapped", `TCS_RESP_SLVERR, resp);
    wctl(16'hffff, 4'hf);
    rc(`TCS_OFF_CTRL, m_ctrl, "ctrl_rw");
    $display("test access done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      wctl(seed[15:0], seed[19:16]);
      rc(`TCS_OFF_CTRL, m_ctrl, "ctrl_wr");
      seed = xs(seed);
      wr(`TCS_OFF_IRQ_MASK, seed);
      m_mask = seed[7:0];
      rc(`TCS_OFF_IRQ_MASK, m_mask, "mask");
      seed = xs(seed);
      ev(seed[8:0]);
      rc(`TCS_OFF_CTRL, m_ctrl, "ctrl_evt");
      rc(`TCS_OFF_IRQ_STAT, m_stat, "stat_evt");
      seed = xs(seed);
      wr(`TCS_OFF_IRQ_STAT, seed);
      m_stat &= ~seed[7:0];
      rc(`TCS_OFF_IRQ_STAT, m_stat, "stat_w1c");
    end
    $display("test events done");
    osc <= 1;
    repeat (8) @(posedge clk);
    m_ctrl[1] = 1;
    m_stat[0] = 1;
    rc(`TCS_OFF_CTRL, m_ctrl, "ctrl_osc");
    rc(`TCS_OFF_IRQ_STAT, m_stat, "stat_osc");
    osc <= 0;
    repeat (4) @(posedge clk);
    rst_b <= 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    #1;
    chk("nest_dis_rst", 0, nest_dis);
    chk("irq_rst", 0, irq);
    rc(`TCS_OFF_CTRL, 0, "ctrl_rst2");
    $display("test second reset done");
    test_done();
  end
endmodule : testbench
